// ### pkg/adc_spi_config_port_map.vh
// Register offsets, field positions and reset values of the serial configuration port.
`ifndef ADC_SPI_CONFIG_PORT_MAP_VH
`define ADC_SPI_CONFIG_PORT_MAP_VH

// Register offsets within the 13-bit address space.
`define REG_SERIAL_PORT_SETUP    13'h0000
`define REG_BURST_STOP_ADDRESS   13'h0002
`define REG_DIE_IDENTIFIER       13'h0008
`define REG_DIE_REVISION         13'h0009
`define REG_CORE_SELECT          13'h0010
`define REG_OFFSET_ADJUST_COARSE 13'h0020
`define REG_OFFSET_ADJUST_FINE   13'h0021

// Field positions of the port setup register.
`define SETUP_FOUR_WIRE_BIT      7
`define SETUP_LSB_FIRST_BIT      6
`define SETUP_SOFT_RESET_BIT     5

// Command word field positions.
`define CMD_READ_BIT             15
`define CMD_LENGTH_HI            14
`define CMD_LENGTH_LO            13
`define CMD_ADDRESS_MSB          12

// Byte count code that means streaming up to the burst stop address.
`define LENGTH_STREAM            2'h3

// Core select values.
`define CORE_NONE                2'h0
`define CORE_FIRST               2'h1
`define CORE_SECOND              2'h2

// Reset values and answers.
`define BURST_STOP_RESET         8'hFF
`define INDEX_ERROR_BYTE         8'hAD
`define UNMAPPED_READ_BYTE       8'h00

`endif

// ### src/bit_sync.v
// Two-stage synchroniser for one asynchronous input.
`timescale 1ns/100ps
module bit_sync
#(
    parameter RESET_VALUE = 1'b0
)
(
    input  wire ref_clk,
    input  wire rst,
    input  wire asyncIn,
    output reg  syncOut
);

    reg stageOne;

    // The first stage feeds only the second stage, never any logic.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            stageOne <= RESET_VALUE; // Matches the idle pin level.
            syncOut  <= RESET_VALUE;
        end
        else
        begin
            stageOne <= asyncIn;
            syncOut  <= stageOne;
        end
    end

endmodule // bit_sync

// ### src/offset_adjust_pair.v
// Coarse and fine offset adjustment registers of one converter core.
`timescale 1ns/100ps
module offset_adjust_pair
(
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       loadCal,
    input  wire [7:0] calCoarse,
    input  wire [7:0] calFine,
    input  wire       writeEnable,
    input  wire       writeFine,
    input  wire [7:0] writeData,
    output reg  [7:0] coarse,
    output reg  [7:0] fine
);

    // Calibration results are taken one cycle after reset release, never during reset.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            coarse <= 8'h00;
            fine   <= 8'h00;
        end
        else if (loadCal)
        begin
            coarse <= calCoarse;
            fine   <= calFine;
        end
        else if (writeEnable)
        begin
            if (writeFine)
                fine <= writeData;
            else
                coarse <= writeData;
        end
    end

endmodule // offset_adjust_pair

// ### src/adc_spi_config_port.v
// Serial configuration slave port with its setup, identity, core select and offset registers.
`timescale 1ns/100ps
`include "adc_spi_config_port_map.vh"
module adc_spi_config_port
#(
    parameter [7:0] DIE_IDENTIFIER_CODE = 8'h5A, // Arbitrary value.
    parameter [7:0] DIE_REVISION_CODE   = 8'h01  // Arbitrary value.
)
(
    input  wire       ref_clk,
    input  wire       rst,
    input  wire       serialClock,
    input  wire       chip_select_n,
    input  wire       sdioIn,
    output reg        sdioOut,
    output reg        sdioOe,
    output reg        serial_data_out,
    output reg        serialDataOutOe,
    input  wire [7:0] calCoarseFirst,
    input  wire [7:0] calFineFirst,
    input  wire [7:0] calCoarseSecond,
    input  wire [7:0] calFineSecond,
    output wire [7:0] offsetCoarseFirst,
    output wire [7:0] offsetFineFirst,
    output wire [7:0] offsetCoarseSecond,
    output wire [7:0] offsetFineSecond,
    output reg  [1:0] coreSelect
);

    // Synchronised pin levels and their delayed copies for edge detection.
    wire        clockSync;
    wire        selectSync;
    wire        dataSync;
    reg         clockDelay;
    reg         selectDelay;
    wire        clockRise;
    wire        clockFall;
    wire        selectRise;

    // Port setup state.
    reg         fourWire;
    reg         lsbFirst;
    reg  [7:0]  burstStop;
    reg         calLoad;

    // Transfer state.
    reg         active;
    reg         inData;
    reg         finished;
    reg  [3:0]  bitCount;
    reg  [15:0] commandShift;
    reg         isRead;
    reg  [1:0]  lengthCode;
    reg  [12:0] address;
    reg  [2:0]  byteCount;
    reg  [7:0]  rxShift;
    reg  [7:0]  txShift;

    // Offset register write port.
    reg         offsetWriteFirst;
    reg         offsetWriteSecond;
    reg         offsetWriteFine;
    reg  [7:0]  offsetWriteData;

    // Combinational helpers.
    reg  [15:0] next_command;
    reg  [7:0]  next_rx;
    reg  [12:0] next_address;
    reg  [7:0]  next_tx;
    reg         next_finished;

    // All pins are asynchronous to ref_clk and pass two flip-flops first.
    bit_sync clockSyncer
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (serialClock),
        .syncOut (clockSync)
    );

    bit_sync #(.RESET_VALUE(1'b1)) selectSyncer // Idle high, so reset shows no false select edge.
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (chip_select_n),
        .syncOut (selectSync)
    );

    bit_sync dataSyncer
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .asyncIn (sdioIn),
        .syncOut (dataSync)
    );

    // Per-core offset registers; only the selected core sees writes.
    offset_adjust_pair firstCore
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .loadCal     (calLoad),
        .calCoarse   (calCoarseFirst),
        .calFine     (calFineFirst),
        .writeEnable (offsetWriteFirst),
        .writeFine   (offsetWriteFine),
        .writeData   (offsetWriteData),
        .coarse      (offsetCoarseFirst),
        .fine        (offsetFineFirst)
    );

    offset_adjust_pair secondCore
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .loadCal     (calLoad),
        .calCoarse   (calCoarseSecond),
        .calFine     (calFineSecond),
        .writeEnable (offsetWriteSecond),
        .writeFine   (offsetWriteFine),
        .writeData   (offsetWriteData),
        .coarse      (offsetCoarseSecond),
        .fine        (offsetFineSecond)
    );

    // Edges are found on the synchronised copies only.
    assign clockRise  = clockSync & ~clockDelay;
    assign clockFall  = ~clockSync & clockDelay;
    assign selectRise = selectSync & ~selectDelay;

    // Indexed registers answer from the selected core, or with the error byte.
    function [7:0] indexedByte;
        input [7:0] firstValue;
        input [7:0] secondValue;
        begin
            if (coreSelect == `CORE_FIRST)
                indexedByte = firstValue;
            else if (coreSelect == `CORE_SECOND)
                indexedByte = secondValue;
            else
                indexedByte = `INDEX_ERROR_BYTE;
        end
    endfunction

    // Read multiplexer; the setup byte reads back in mirrored form.
    function [7:0] readByte;
        input [12:0] regAddress;
        begin
            case (regAddress)
                `REG_SERIAL_PORT_SETUP:
                    readByte = {fourWire, lsbFirst, 1'b0, 1'b1, 1'b1, 1'b0, lsbFirst, fourWire};
                `REG_BURST_STOP_ADDRESS:
                    readByte = burstStop;
                `REG_DIE_IDENTIFIER:
                    readByte = DIE_IDENTIFIER_CODE;
                `REG_DIE_REVISION:
                    readByte = DIE_REVISION_CODE;
                `REG_CORE_SELECT:
                    readByte = {6'h00, coreSelect};
                `REG_OFFSET_ADJUST_COARSE:
                    readByte = indexedByte(offsetCoarseFirst, offsetCoarseSecond);
                `REG_OFFSET_ADJUST_FINE:
                    readByte = indexedByte(offsetFineFirst, offsetFineSecond);
                default:
                    readByte = `UNMAPPED_READ_BYTE;
            endcase
        end
    endfunction

    // First bit of a read byte in the present bit order.
    function firstBit;
        input [7:0] value;
        firstBit = lsbFirst ? value[0] : value[7];
    endfunction

    // Shift paths, address step and end-of-transfer decision for the current bit.
    always @*
    begin
        next_command  = 16'h0000;
        next_rx       = 8'h00;
        next_address  = 13'h0000;
        next_tx       = 8'h00;
        next_finished = 1'b0;
        if (lsbFirst)
        begin
            next_command = {dataSync, commandShift[15:1]};
            next_rx      = {dataSync, rxShift[7:1]};
            next_address = address - 13'h0001;
            next_tx      = {1'b0, txShift[7:1]};
        end
        else
        begin
            next_command = {commandShift[14:0], dataSync};
            next_rx      = {rxShift[6:0], dataSync};
            next_address = address + 13'h0001;
            next_tx      = {txShift[6:0], 1'b0};
        end
        // Short transfers stop at the coded count; streaming stops at the stop address.
        if (lengthCode != `LENGTH_STREAM)
            next_finished = (byteCount == {1'b0, lengthCode});
        else
            next_finished = (address == {5'h00, burstStop});
    end

    // Protocol engine and register file share one process so writes land in order.
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            clockDelay        <= 1'b0;
            selectDelay       <= 1'b1;
            fourWire          <= 1'b0;
            lsbFirst          <= 1'b0;
            burstStop         <= `BURST_STOP_RESET;
            coreSelect        <= `CORE_NONE;
            calLoad           <= 1'b1;
            active            <= 1'b0;
            inData            <= 1'b0;
            finished          <= 1'b0;
            bitCount          <= 4'h0;
            commandShift      <= 16'h0000;
            isRead            <= 1'b0;
            lengthCode        <= 2'h0;
            address           <= 13'h0000;
            byteCount         <= 3'h0;
            rxShift           <= 8'h00;
            txShift           <= 8'h00;
            offsetWriteFirst  <= 1'b0;
            offsetWriteSecond <= 1'b0;
            offsetWriteFine   <= 1'b0;
            offsetWriteData   <= 8'h00;
            sdioOut           <= 1'b0;
            sdioOe            <= 1'b0;
            serial_data_out   <= 1'b0;
            serialDataOutOe   <= 1'b0;
        end
        else
        begin
            clockDelay        <= clockSync;
            selectDelay       <= selectSync;
            calLoad           <= 1'b0;
            offsetWriteFirst  <= 1'b0;
            offsetWriteSecond <= 1'b0;

            // A pause is kept only at a byte boundary of a transfer that may still resume.
            if (selectRise && active)
            begin
                if ((bitCount[2:0] != 3'h0) || finished ||
                    (inData && (lengthCode == `LENGTH_STREAM) && (byteCount != 3'h0)))
                begin
                    active    <= 1'b0;
                    inData    <= 1'b0;
                    finished  <= 1'b0;
                    bitCount  <= 4'h0;
                    byteCount <= 3'h0;
                end
            end
            else if (clockRise && !selectSync && !finished)
            begin
                // The first rise while selected is the first command bit.
                active <= 1'b1;
                if (!inData)
                begin
                    commandShift <= next_command;
                    bitCount     <= bitCount + 4'h1;
                    if (bitCount == 4'hF)
                    begin
                        inData     <= 1'b1;
                        bitCount   <= 4'h0;
                        isRead     <= next_command[`CMD_READ_BIT];
                        lengthCode <= next_command[`CMD_LENGTH_HI:`CMD_LENGTH_LO];
                        address    <= next_command[`CMD_ADDRESS_MSB:0];
                        txShift    <= readByte(next_command[`CMD_ADDRESS_MSB:0]);
                        sdioOut    <= firstBit(readByte(next_command[`CMD_ADDRESS_MSB:0]));
                    end
                end
                else
                begin
                    rxShift  <= next_rx;
                    bitCount <= {1'b0, bitCount[2:0] + 3'h1};
                    if (bitCount[2:0] == 3'h7)
                    begin
                        // Byte complete: store a write, step the address, prepare the next read.
                        bitCount <= 4'h0;
                        address  <= next_address;
                        finished <= next_finished;
                        if (byteCount != 3'h4)
                            byteCount <= byteCount + 3'h1;
                        if (isRead)
                        begin
                            txShift <= readByte(next_address);
                            // The last bit stays on the pin; nothing past the end is shown.
                            if (!next_finished)
                                sdioOut <= firstBit(readByte(next_address));
                        end
                        else
                        begin
                            case (address)
                                `REG_SERIAL_PORT_SETUP:
                                begin
                                    if (next_rx[`SETUP_SOFT_RESET_BIT])
                                    begin
                                        // Soft reset wins over the bits written with it.
                                        fourWire   <= 1'b0;
                                        lsbFirst   <= 1'b0;
                                        burstStop  <= `BURST_STOP_RESET;
                                        coreSelect <= `CORE_NONE;
                                        calLoad    <= 1'b1;
                                    end
                                    else
                                    begin
                                        fourWire <= next_rx[`SETUP_FOUR_WIRE_BIT];
                                        lsbFirst <= next_rx[`SETUP_LSB_FIRST_BIT];
                                    end
                                end
                                `REG_BURST_STOP_ADDRESS:
                                    burstStop <= next_rx;
                                `REG_CORE_SELECT:
                                    coreSelect <= next_rx[1:0];
                                `REG_OFFSET_ADJUST_COARSE,
                                `REG_OFFSET_ADJUST_FINE:
                                begin
                                    // Writes with no valid core selected are dropped.
                                    offsetWriteFirst  <= (coreSelect == `CORE_FIRST);
                                    offsetWriteSecond <= (coreSelect == `CORE_SECOND);
                                    offsetWriteFine   <= address[0];
                                    offsetWriteData   <= next_rx;
                                end
                                default:
                                    offsetWriteData <= offsetWriteData;
                            endcase
                        end
                    end
                end
            end
            else if (clockFall && inData && isRead && !finished && (bitCount[2:0] != 3'h0))
            begin
                // Read data changes on the falling edge so it is stable at the next rise.
                txShift <= next_tx;
                sdioOut <= firstBit(next_tx);
            end

            // Pin direction follows the command; released on the clock after the synchronised select goes high.
            sdioOe          <= !fourWire && isRead && inData && active &&
                               !finished && !selectSync;
            serial_data_out <= sdioOut;
            // The separate output is driven whenever four-wire mode is on.
            serialDataOutOe <= fourWire;
        end
    end

endmodule // adc_spi_config_port

// ### tb/adc_spi_config_port_monitor.sv
// Concurrent checks on the outputs of the serial configuration port.
`timescale 1ns/100ps
module adc_spi_config_port_monitor
(
    input wire       ref_clk,
    input wire       rst,
    input wire       chip_select_n,
    input wire       sdioOe,
    input wire       serialDataOutOe,
    input wire [7:0] calCoarseFirst,
    input wire [7:0] calFineFirst,
    input wire [7:0] calCoarseSecond,
    input wire [7:0] calFineSecond,
    input wire [7:0] offsetCoarseFirst,
    input wire [7:0] offsetFineFirst,
    input wire [7:0] offsetCoarseSecond,
    input wire [7:0] offsetFineSecond,
    input wire [1:0] coreSelect
);
    // Every check runs on the system clock and stays quiet while reset is held.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_release_pin;
        chip_select_n [*6] |-> !sdioOe;
    endproperty
    a_release_pin: assert property (p_release_pin)
        else $error("data pin driven while deselected");

    property p_pin_direction;
        serialDataOutOe |-> !sdioOe;
    endproperty
    a_pin_direction: assert property (p_pin_direction)
        else $error("data pin driven in four-wire mode");

    property p_cal_first;
        $fell(rst) |-> ##[1:2] (offsetCoarseFirst == calCoarseFirst && offsetFineFirst == calFineFirst);
    endproperty
    a_cal_first: assert property (p_cal_first)
        else $error("first core offsets not loaded from calibration");

    property p_cal_second;
        $fell(rst) |-> ##[1:2] (offsetCoarseSecond == calCoarseSecond
            && offsetFineSecond == calFineSecond);
    endproperty
    a_cal_second: assert property (p_cal_second)
        else $error("second core offsets not loaded from calibration");

    // Registers may only move while a transfer is under way.
    property p_idle_stable;
        chip_select_n [*8] |-> $stable({offsetCoarseFirst, offsetFineFirst, offsetCoarseSecond,
            offsetFineSecond, coreSelect});
    endproperty
    a_idle_stable: assert property (p_idle_stable)
        else $error("register changed while deselected");

    property p_select_commit;
        $changed({coreSelect, serialDataOutOe}) |-> !$past(chip_select_n, 3) || !$past(chip_select_n, 5);
    endproperty
    a_select_commit: assert property (p_select_commit)
        else $error("setting changed without a selected transfer");

    property p_oe_start;
        $rose(sdioOe) |-> !chip_select_n && !$past(chip_select_n, 3);
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("data pin driven outside a transfer");

    property p_oe_hold;
        $rose(sdioOe) |=> (sdioOe || chip_select_n) [*8];
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("read data dropped in mid byte");

    property p_reset_values;
        $fell(rst) |-> !sdioOe && !serialDataOutOe && coreSelect == 2'h0;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("outputs not at reset values");
endmodule // adc_spi_config_port_monitor

// ### tb/spi_master_model.sv
// Serial master that runs transfers on the port and resolves the shared data pin.
`timescale 1ns/100ps
module spi_master_model
(
    input  wire       refClk,
    input  wire       sdioOut,
    input  wire       sdioOe,
    input  wire       serialOut,
    output reg        serialClock,
    output reg        chipSelectN,
    output wire       sdioLine,
    output reg  [7:0] rxByte,
    output reg        rxValid
);
    reg lsbFirst;
    reg fourWire;
    reg masterOe;
    reg masterBit;
    reg lastLevel;

    // The pin has no pull, so once released it shows the inverse of its last driven level.
    assign sdioLine = sdioOe ? sdioOut : (masterOe ? masterBit : ~lastLevel);

    // Track the last level any party drove.
    always @(posedge refClk)
    begin
        if (sdioOe || masterOe)
            lastLevel <= sdioLine;
    end

    // Idle: deselected, clock low, pin released.
    initial
    begin
        serialClock = 1'b0;
        chipSelectN = 1'b1;
        rxValid = 1'b0;
        lsbFirst = 1'b0;
        fourWire = 1'b0;
        masterOe = 1'b0;
        lastLevel = 1'b0;
    end

    // Wait n system clocks and step just past the edge.
    task tick(input integer n);
        begin
            repeat (n) @(posedge refClk);
            #1;
        end
    endtask

    // Command bytes, then data bytes; one select pause before the data if asked.
    task xfer(input [15:0] cmd, input integer nBytes, input [31:0] wr, input pause);
        integer i;
        integer b;
        reg [7:0] sh;
        begin
            chipSelectN = 1'b0;
            for (i = 0; i < nBytes + 2; i = i + 1)
            begin
                if (pause && i == 2)
                begin
                    chipSelectN = 1'b1;
                    tick(12);
                    chipSelectN = 1'b0;
                end
                if (i >= 2)
                    sh = wr[8 * (i - 2) +: 8];
                else
                    sh = ((i == 0) ^ lsbFirst) ? cmd[15:8] : cmd[7:0];
                masterOe = !(cmd[15] && i >= 2);
                for (b = 0; b < 8; b = b + 1)
                begin
                    masterBit = lsbFirst ? sh[b] : sh[7 - b];
                    tick(4); // Half period of 100 ns
                    // Read data is taken at the rising edge, before the port moves on.
                    rxByte[lsbFirst ? b : 7 - b] = fourWire ? serialOut : sdioLine;
                    serialClock = 1'b1;
                    tick(4);
                    serialClock = 1'b0;
                end
                if (!masterOe)
                begin
                    rxValid = 1'b1;
                    tick(1);
                    rxValid = 1'b0;
                end
            end
            masterOe = 1'b0;
            tick(4);
            chipSelectN = 1'b1;
            tick(8);
        end
    endtask
endmodule // spi_master_model

// ### tb/testbench.sv
// Top bench: resets the port, runs register scenarios and checks every read byte.
`timescale 1ns/100ps
bind adc_spi_config_port adc_spi_config_port_monitor mon
(
    .ref_clk(ref_clk), .rst(rst), .chip_select_n(chip_select_n), .sdioOe(sdioOe),
    .serialDataOutOe(serialDataOutOe), .calCoarseFirst(calCoarseFirst),
    .calFineFirst(calFineFirst), .calCoarseSecond(calCoarseSecond),
    .calFineSecond(calFineSecond), .offsetCoarseFirst(offsetCoarseFirst),
    .offsetFineFirst(offsetFineFirst), .offsetCoarseSecond(offsetCoarseSecond),
    .offsetFineSecond(offsetFineSecond), .coreSelect(coreSelect)
);
module testbench;
    localparam [7:0] ID_CODE  = 8'hC3; // Arbitrary value.
    localparam [7:0] REV_CODE = 8'h27; // Arbitrary value.
    reg         ref_clk;
    reg         rst;
    reg  [7:0]  cal [0:3];
    wire [7:0]  offset [0:3];
    wire        serialClock;
    wire        chipSelectN;
    wire        sdioLine;
    wire        sdioOut;
    wire        sdioOe;
    wire        serialOut;
    wire        serialOutOe;
    wire [1:0]  coreSelect;
    wire [7:0]  rxByte;
    wire        rxValid;
    reg  [7:0]  expQ [$];
    integer     failCount;
    integer     nTests;
    integer     seed;
    reg  [15:0] wv;

    adc_spi_config_port #(.DIE_IDENTIFIER_CODE(ID_CODE), .DIE_REVISION_CODE(REV_CODE)) dut
    (
        .ref_clk(ref_clk), .rst(rst), .serialClock(serialClock), .chip_select_n(chipSelectN),
        .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe), .serial_data_out(serialOut),
        .serialDataOutOe(serialOutOe), .calCoarseFirst(cal[0]), .calFineFirst(cal[1]),
        .calCoarseSecond(cal[2]), .calFineSecond(cal[3]), .offsetCoarseFirst(offset[0]),
        .offsetFineFirst(offset[1]), .offsetCoarseSecond(offset[2]),
        .offsetFineSecond(offset[3]), .coreSelect(coreSelect)
    );

    spi_master_model master
    (
        .refClk(ref_clk), .sdioOut(sdioOut), .sdioOe(sdioOe), .serialOut(serialOut),
        .serialClock(serialClock), .chipSelectN(chipSelectN), .sdioLine(sdioLine),
        .rxByte(rxByte), .rxValid(rxValid)
    );

    // 40 MHz system clock.
    always #12.5 ref_clk = ~ref_clk;

    task comparePort(input [8*12:1] what, input [7:0] exp, input [7:0] got);
        begin
            nTests = nTests + 1;
            if (got !== exp)
            begin
                failCount = failCount + 1;
                $display("unexpected %0s: expected %h seen %h", what, exp, got);
            end
        end
    endtask

    task compareByte(input [7:0] exp, input [7:0] got);
        begin
            comparePort("read byte", exp, got);
        end
    endtask

    task endTest(input [8*12:1] name);
        begin
            $display("test %0s finished", name);
        end
    endtask

    task testDone;
        begin
            if (expQ.size() != 0)
                failCount = failCount + 1;
            $display("comparisons %0d mismatches %0d", nTests, failCount);
            if (failCount == 0 && nTests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // Each byte the master collects is matched against the oldest expected byte.
    always @(posedge ref_clk)
    begin
        if (rxValid === 1'b1)
            compareByte(expQ.size() ? expQ.pop_front() : 8'hXX, rxByte);
    end

    // A hang is cut short well past the expected run of about 4300 cycles.
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        failCount = failCount + 1;
        testDone;
    end

    initial
    begin
        seed = 32'h3446;
        failCount = 0;
        nTests = 0;
        ref_clk = 1'b0;
        rst = 1'b1;
        cal[0] = $random(seed);
        cal[1] = $random(seed);
        cal[2] = $random(seed);
        cal[3] = $random(seed);
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        // Identity pair read upward; a write to a read-only place is ignored.
        expQ.push_back(ID_CODE);
        expQ.push_back(REV_CODE);
        master.xfer(16'hA008, 2, 0, 0);
        master.xfer(16'h0008, 1, 32'h33, 0);
        expQ.push_back(ID_CODE);
        master.xfer(16'h8008, 1, 0, 0);
        endTest("identity");
        // Indexed reads need a selected core.
        expQ.push_back(8'hAD);
        master.xfer(16'h8020, 1, 0, 0);
        master.xfer(16'h0010, 1, 1, 0);
        comparePort("core select", 8'h01, {6'h00, coreSelect});
        expQ.push_back(cal[0]);
        expQ.push_back(cal[1]);
        master.xfer(16'hA020, 2, 0, 0);
        wv = $random(seed);
        wv[7:0] = cal[0] + 8'h01;
        master.xfer(16'h2020, 2, {16'h0000, wv}, 1);
        comparePort("coarse", wv[7:0], offset[0]);
        expQ.push_back(wv[7:0]);
        expQ.push_back(wv[15:8]);
        master.xfer(16'hA020, 2, 0, 0);
        master.xfer(16'h0010, 1, 2, 0);
        comparePort("core select", 8'h02, {6'h00, coreSelect});
        expQ.push_back(cal[2]);
        master.xfer(16'h8020, 1, 0, 0);
        endTest("indexed");
        // Bit order reversed, address steps down, then soft reset.
        master.xfer(16'h0000, 1, 8'h5A, 0);
        master.lsbFirst = 1'b1;
        expQ.push_back(REV_CODE);
        expQ.push_back(ID_CODE);
        master.xfer(16'hA009, 2, 0, 0);
        master.xfer(16'h0000, 1, 8'h3C, 0);
        master.lsbFirst = 1'b0;
        comparePort("core select", 8'h00, {6'h00, coreSelect});
        comparePort("coarse", cal[0], offset[0]);
        expQ.push_back(8'hAD);
        master.xfer(16'h8020, 1, 0, 0);
        endTest("bit order");
        // Four-wire read on the separate output.
        master.xfer(16'h0000, 1, 8'h99, 0);
        master.fourWire = 1'b1;
        comparePort("four wire", 8'h01, {7'h00, serialOutOe});
        expQ.push_back(ID_CODE);
        master.xfer(16'h8008, 1, 0, 0);
        master.xfer(16'h0000, 1, 8'h18, 0);
        master.fourWire = 1'b0;
        endTest("four wire");
        // Streaming read stops at the burst stop address and releases the pin.
        master.xfer(16'h0002, 1, 8'h08, 0);
        expQ.push_back(ID_CODE);
        expQ.push_back({8{~ID_CODE[0]}});
        master.xfer(16'hE008, 2, 0, 0);
        endTest("burst stop");
        repeat (8) @(posedge ref_clk);
        testDone;
    end
endmodule // testbench
